// ---- logic/icts_index_compare_logic.sv ----
`timescale 1ns/1ps
// How it works
// - control via output channels, status via input channels
// - key, key plus address, delete operations
// - scans table of 64-bit entries
// - table words only in even banks
// - holds up to six 18-bit request words
// - one key, two keys, or key-address pairs
// - backward scan from high to low limit
// - delete sets null bit 15 of key
// - delete chosen by request 0 bit 13
// - delete keeps scanning after a match
// - delete ends only on end-of-table, parity error, clear
// - delete writes matched entries back, key search does not
// - channel 6 bits 0-2 gate channel 7 word
// - channel 6 bit 4 starts, bit 3 clears
// - end-of-table when address reaches limit
// - channel 6 bit 5 writes buffers back
module icts_index_compare_logic (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [2:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   output logic irq,
   output logic mem_req,
   output logic mem_we,
   output logic [11:0] mem_addr,
   output logic [2:0] mem_bank,
   output logic [15:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_perr
);
   // ****************************************
   // channel registers
   // ****************************************
   logic [15:0] noc5;
   logic [15:0] noc6;
   logic [15:0] noc7;
   logic [15:0] stb;
   logic [2:0] req_cnt;
   logic [icts_pkg::REQ_W-1:0] req [icts_pkg::REQ_N];
   logic [15:0] ebuf [icts_pkg::ENTRY_WORDS];
   logic [11:0] sa;
   logic [11:0] ta;
   logic [11:0] cur;
   logic [1:0] wcnt;
   icts_pkg::icts_state_t state;
   logic back;
   logic del;
   logic resume;
   logic hit0;
   logic hit1;
   logic eot;
   logic perr;
   logic [2:0] err_bank;
   logic [icts_pkg::IRQ_W-1:0] irq_st;
   logic [icts_pkg::IRQ_W-1:0] irq_mask;
   logic [icts_pkg::IRQ_W-1:0] evt;
   logic clr;
   logic start;
   logic last_addr;
   logic [icts_pkg::REQ_N-1:0] key_eq;
   logic [icts_pkg::REQ_N-1:0] va_eq;
   logic [1:0] have_key;
   logic [1:0] have_va;
   logic [1:0] key_ok;
   logic [1:0] va_ok;
   logic del_req;
   logic m0;
   logic m1;
   logic any_hit;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         noc5 <= icts_pkg::NOC_RST;
         noc6 <= icts_pkg::NOC_RST;
         noc7 <= icts_pkg::NOC_RST;
      end else if (wr) begin
         if (addr == icts_pkg::A_NOC5) begin
            noc5 <= wdata;
         end
         if (addr == icts_pkg::A_NOC6) begin
            noc6 <= wdata;
         end
         if (addr == icts_pkg::A_NOC7) begin
            noc7 <= wdata;
         end
      end
   end

   // strobe bits act only in the cycle of the channel 6 write
   assign stb = (wr && addr == icts_pkg::A_NOC6) ? wdata : 16'h0000;
   assign clr = stb[icts_pkg::B_CLR];
   assign start = stb[icts_pkg::B_START] && state == icts_pkg::ST_IDLE;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sa <= 12'h000;
         ta <= 12'h000;
      end else begin
         if (stb[icts_pkg::B_SA]) begin
            sa <= noc7[11:0];
         end
         if (stb[icts_pkg::B_TA]) begin
            ta <= noc7[11:0];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_cnt <= 3'h0;
         for (int i = 0; i < icts_pkg::REQ_N; i++) begin
            req[i] <= 18'h00000;
         end
      end else if (clr) begin
         req_cnt <= 3'h0;
      end else if (stb[icts_pkg::B_REQ] && req_cnt < 3'(icts_pkg::REQ_N)) begin
         req[req_cnt] <= {noc5[icts_pkg::B_REQID], noc5[icts_pkg::B_KEYID], noc7};
         req_cnt <= req_cnt + 3'h1;
      end
   end

   // ****************************************
   // compare
   // ****************************************
   for (genvar g = 0; g < icts_pkg::REQ_N; g++) begin : g_slot
      assign key_eq[g] = req[g][icts_pkg::KEY_MSB:0] == ebuf[0][icts_pkg::KEY_MSB:0];
      assign va_eq[g] = req[g][15:0] == ebuf[1];
   end

   always_comb begin
      have_key = 2'h0;
      have_va = 2'h0;
      key_ok = 2'h0;
      va_ok = 2'h0;
      del_req = 1'b0;
      for (int i = 0; i < icts_pkg::REQ_N; i++) begin
         if (i < int'(req_cnt)) begin
            if (!have_key[req[i][17]]) begin
               have_key[req[i][17]] = 1'b1;
               key_ok[req[i][17]] = key_eq[i];
               if (!req[i][17]) begin
                  del_req = req[i][icts_pkg::B_DEL];
               end
            end else if (!have_va[req[i][17]]) begin
               have_va[req[i][17]] = 1'b1;
               va_ok[req[i][17]] = va_eq[i];
            end
         end
      end
   end

   // null entries match only the one-request search
   assign m0 = ebuf[0][icts_pkg::B_NULL] ? noc6[icts_pkg::B_ONE]
             : (have_key[0] && key_ok[0] && (!have_va[0] || va_ok[0]));
   assign m1 = !ebuf[0][icts_pkg::B_NULL] && have_key[1] && key_ok[1] && (!have_va[1] || va_ok[1]);
   assign any_hit = m0 || m1;
   assign last_addr = cur == (back ? sa : ta);

   // ****************************************
   // scan sequencer
   // ****************************************
   // search engine
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= icts_pkg::ST_IDLE;
         cur <= 12'h000;
         wcnt <= 2'h0;
         back <= 1'b0;
         del <= 1'b0;
         resume <= 1'b0;
      end else if (clr) begin
         state <= icts_pkg::ST_IDLE;
         wcnt <= 2'h0;
      end else begin
         unique case (state)
            icts_pkg::ST_IDLE: begin
               wcnt <= 2'h0;
               if (start) begin
                  back <= noc6[icts_pkg::B_BACK];
                  cur <= noc6[icts_pkg::B_BACK] ? ta : sa;
                  del <= del_req;
                  state <= icts_pkg::ST_FETCH;
               end else if (stb[icts_pkg::B_WRBUF]) begin
                  resume <= 1'b0;
                  state <= icts_pkg::ST_WRITE;
               end
            end
            icts_pkg::ST_FETCH: begin
               if (mem_ack) begin
                  if (mem_perr) begin
                     state <= icts_pkg::ST_IDLE;
                  end else if (wcnt == 2'h3) begin
                     state <= icts_pkg::ST_CMP;
                  end
                  wcnt <= wcnt + 2'h1;
               end
            end
            icts_pkg::ST_CMP: begin
               if (any_hit && del && !ebuf[0][icts_pkg::B_NULL]) begin
                  resume <= 1'b1;
                  state <= icts_pkg::ST_WRITE;
               end else if (any_hit && !del) begin
                  state <= icts_pkg::ST_IDLE;
               end else begin
                  state <= icts_pkg::ST_STEP;
               end
            end
            icts_pkg::ST_STEP: begin
               if (last_addr) begin
                  state <= icts_pkg::ST_IDLE;
               end else begin
                  cur <= back ? cur - 12'h001 : cur + 12'h001;
                  state <= icts_pkg::ST_FETCH;
               end
            end
            icts_pkg::ST_WRITE: begin
               if (mem_ack) begin
                  wcnt <= wcnt + 2'h1;
                  if (wcnt == 2'h3) begin
                     state <= resume ? icts_pkg::ST_STEP : icts_pkg::ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < icts_pkg::ENTRY_WORDS; i++) begin
            ebuf[i] <= 16'h0000;
         end
      end else if (state == icts_pkg::ST_FETCH && mem_ack) begin
         ebuf[wcnt] <= mem_rdata;
      end else if (state == icts_pkg::ST_CMP && any_hit && del) begin
         ebuf[0][icts_pkg::B_NULL] <= 1'b1;
      end
   end

   assign mem_bank = {wcnt, 1'b0};
   assign mem_addr = cur;
   assign mem_req = state == icts_pkg::ST_FETCH;
   assign mem_we = state == icts_pkg::ST_WRITE;
   assign mem_wdata = ebuf[wcnt];

   // ****************************************
   // status flags
   // ****************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hit0 <= 1'b0;
         hit1 <= 1'b0;
         eot <= 1'b0;
         perr <= 1'b0;
         err_bank <= 3'h0;
      end else if (clr || start) begin
         hit0 <= 1'b0;
         hit1 <= 1'b0;
         eot <= 1'b0;
         perr <= 1'b0;
      end else begin
         if (state == icts_pkg::ST_CMP) begin
            hit0 <= hit0 || m0;
            hit1 <= hit1 || m1;
         end
         if (state == icts_pkg::ST_STEP && last_addr) begin
            eot <= 1'b1;
         end
         if (state == icts_pkg::ST_FETCH && mem_ack && mem_perr) begin
            perr <= 1'b1;
            err_bank <= mem_bank;
         end
      end
   end

   assign evt[icts_pkg::IRQ_DONE] = state == icts_pkg::ST_STEP && last_addr
                                  || state == icts_pkg::ST_CMP && any_hit && !del;
   assign evt[icts_pkg::IRQ_HIT] = state == icts_pkg::ST_CMP && any_hit;
   assign evt[icts_pkg::IRQ_PERR] = state == icts_pkg::ST_FETCH && mem_ack && mem_perr;

   // set wins over write-one clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_st <= icts_pkg::IRQ_RST;
         irq_mask <= icts_pkg::IRQ_RST;
      end else begin
         if (wr && addr == icts_pkg::A_IRQ_MASK) begin
            irq_mask <= wdata[icts_pkg::IRQ_W-1:0];
         end
         if (wr && addr == icts_pkg::A_IRQ_ST) begin
            irq_st <= (irq_st & ~wdata[icts_pkg::IRQ_W-1:0]) | evt;
         end else begin
            irq_st <= irq_st | evt;
         end
      end
   end

   assign irq = |(irq_st & irq_mask);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 16'h0000;
      end else if (rd) begin
         unique case (addr)
            icts_pkg::A_NOC5: rdata <= noc5;
            icts_pkg::A_NOC6: rdata <= noc6;
            icts_pkg::A_NOC7: rdata <= noc7;
            icts_pkg::A_NIC5: rdata <= {12'h000, err_bank, perr};
            icts_pkg::A_NIC6: rdata <= {9'h000, eot, hit1, !perr, hit0, 1'b0, del, state != icts_pkg::ST_IDLE};
            icts_pkg::A_NIC7: rdata <= {4'h0, cur};
            icts_pkg::A_IRQ_ST: rdata <= {13'h0000, irq_st};
            icts_pkg::A_IRQ_MASK: rdata <= {13'h0000, irq_mask};
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence s_start_cmd;
      wr && addr == icts_pkg::A_NOC6 && wdata[icts_pkg::B_START] && !wdata[icts_pkg::B_CLR]
         && state == icts_pkg::ST_IDLE;
   endsequence
   sequence s_fetch_word;
      state == icts_pkg::ST_FETCH && mem_ack && !mem_perr;
   endsequence

   property p_bank_even;
      @(posedge ref_clk) disable iff (!rst_n) (mem_req || mem_we) |-> !mem_bank[0];
   endproperty
   a_bank_even: assert property (p_bank_even) else $error("odd bank addressed");

   property p_sa_gate;
      @(posedge ref_clk) disable iff (!rst_n)
         wr && addr == icts_pkg::A_NOC6 && wdata[icts_pkg::B_SA] |=> sa == $past(noc7[11:0]);
   endproperty
   a_sa_gate: assert property (p_sa_gate) else $error("start limit not loaded");

   property p_start;
      @(posedge ref_clk) disable iff (!rst_n)
         s_start_cmd |=> state == icts_pkg::ST_FETCH && cur == (back ? $past(ta) : $past(sa));
   endproperty
   a_start: assert property (p_start) else $error("scan did not start at limit");

   property p_clear;
      @(posedge ref_clk) disable iff (!rst_n) clr |=> state == icts_pkg::ST_IDLE && req_cnt == 3'h0;
   endproperty
   a_clear: assert property (p_clear) else $error("clear ignored");

   property p_entry;
      @(posedge ref_clk) disable iff (!rst_n)
         s_fetch_word and wcnt == 2'h3 && !clr |=> state == icts_pkg::ST_CMP;
   endproperty
   a_entry: assert property (p_entry) else $error("entry not compared after four words");

   property p_null;
      @(posedge ref_clk) disable iff (!rst_n)
         state == icts_pkg::ST_CMP && any_hit && del && !ebuf[0][icts_pkg::B_NULL] && !clr
         |=> state == icts_pkg::ST_WRITE && ebuf[0][icts_pkg::B_NULL];
   endproperty
   a_null: assert property (p_null) else $error("deleted entry not nulled");

   property p_first_hit;
      @(posedge ref_clk) disable iff (!rst_n)
         state == icts_pkg::ST_CMP && any_hit && !del && !clr |=> state == icts_pkg::ST_IDLE ##0 (hit0 || hit1);
   endproperty
   a_first_hit: assert property (p_first_hit) else $error("key search ran past hit");

   property p_del_go_on;
      @(posedge ref_clk) disable iff (!rst_n)
         state == icts_pkg::ST_WRITE && resume && mem_ack && wcnt == 2'h3 && !clr |=> state == icts_pkg::ST_STEP;
   endproperty
   a_del_go_on: assert property (p_del_go_on) else $error("delete stopped after match");

   property p_eot;
      @(posedge ref_clk) disable iff (!rst_n)
         state == icts_pkg::ST_STEP && last_addr && !clr |=> eot && state == icts_pkg::ST_IDLE;
   endproperty
   a_eot: assert property (p_eot) else $error("end of table not flagged");

   property p_perr;
      @(posedge ref_clk) disable iff (!rst_n)
         state == icts_pkg::ST_FETCH && mem_ack && mem_perr && !clr |=> perr && state == icts_pkg::ST_IDLE;
   endproperty
   a_perr: assert property (p_perr) else $error("parity error did not end scan");
endmodule : icts_index_compare_logic

// ---- logic/icts_pkg.sv ----
package icts_pkg;
   localparam int DATA_W = 16;
   localparam int MA_W = 12;
   localparam int REQ_W = 18;
   localparam int REQ_N = 6;
   localparam int ENTRY_WORDS = 4;
   localparam int IRQ_W = 3;
   // ****************************************
   // register port word addresses
   // ****************************************
   localparam logic [2:0] A_NOC5 = 3'h0;
   localparam logic [2:0] A_NOC6 = 3'h1;
   localparam logic [2:0] A_NOC7 = 3'h2;
   localparam logic [2:0] A_NIC5 = 3'h3;
   localparam logic [2:0] A_NIC6 = 3'h4;
   localparam logic [2:0] A_NIC7 = 3'h5;
   localparam logic [2:0] A_IRQ_ST = 3'h6;
   localparam logic [2:0] A_IRQ_MASK = 3'h7;
   localparam logic [15:0] NOC_RST = 16'h0000;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
   // ****************************************
   // field positions
   // ****************************************
   localparam int B_SA = 0;
   localparam int B_TA = 1;
   localparam int B_REQ = 2;
   localparam int B_CLR = 3;
   localparam int B_START = 4;
   localparam int B_WRBUF = 5;
   localparam int B_BACK = 6;
   localparam int B_ONE = 7;
   localparam int B_KEYID = 14;
   localparam int B_REQID = 15;
   localparam int B_NULL = 15;
   localparam int B_DEL = 13;
   localparam int KEY_MSB = 12;
   localparam int B_BUSY = 0;
   localparam int B_DEL_MODE = 1;
   localparam int B_HIT0 = 3;
   localparam int B_NOPERR = 4;
   localparam int B_HIT1 = 5;
   localparam int B_EOT = 6;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_HIT = 1;
   localparam int IRQ_PERR = 2;
   typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_CMP, ST_STEP, ST_WRITE} icts_state_t;
endpackage : icts_pkg

// ---- test/icts_mem_model.sv ----
`timescale 1ns/1ps
// ********
// buffer memory, one word per ack, slow by wait count
// ********
module icts_mem_model (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [11:0] mem_addr,
   input wire logic [2:0] mem_bank,
   input wire logic [15:0] mem_wdata,
   output logic mem_ack,
   output logic [15:0] mem_rdata,
   output logic mem_perr,
   input wire logic [3:0] slow,
   input wire logic perr_en,
   input wire logic [11:0] perr_addr
);
   logic [15:0] mem [0:16383];
   logic [3:0] cnt;
   logic [13:0] idx;
   assign idx = {mem_addr, mem_bank[2:1]};
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_ack <= 1'b0;
         mem_perr <= 1'b0;
         mem_rdata <= 16'hFFFF;
         cnt <= 4'h0;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         mem_perr <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt <= 4'h0;
         if (mem_we) begin
            mem[idx] <= mem_wdata;
         end
      end else if ((mem_req || mem_we) && cnt >= slow) begin
         mem_ack <= 1'b1;
         mem_rdata <= mem[idx];
         mem_perr <= perr_en && mem_req && mem_addr == perr_addr && mem_bank == 3'h0;
      end else if (mem_req || mem_we) begin
         cnt <= cnt + 4'h1;
      end else begin
         cnt <= 4'h0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : icts_mem_model

// ---- test/test_index_compare_table_search.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
   $display("CHECK FAILED at %0t: got %0h exp %0h", $time, (a), (e)); end end
module test_index_compare_table_search;
   logic ref_clk, rst_n, wr, rd, irq, mem_req, mem_we, mem_ack, mem_perr, perr_en;
   logic [2:0] addr, mem_bank;
   logic [15:0] wdata, rdata, mem_wdata, mem_rdata, mode;
   logic [11:0] mem_addr, perr_addr;
   logic [3:0] slow;
   int failures, n_checks, cycles, n_acks, n_wr;
   icts_index_compare_logic u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .irq(irq), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_bank(mem_bank), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_perr(mem_perr));
   icts_mem_model u_mem (.ref_clk(ref_clk), .rst_n(rst_n), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_bank(mem_bank), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .mem_perr(mem_perr), .slow(slow), .perr_en(perr_en), .perr_addr(perr_addr));
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (mem_ack) begin
         n_acks++;
         n_wr += mem_we;
         `CHK(mem_bank[0], 1'b0)
      end
      if (cycles == 40000) begin
         failures++;
         complete_run;
      end
   end
   // ********
   // register port and table helpers
   // ********
   task wr_reg(input logic [2:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr_reg
   task rd_reg(input logic [2:0] a, output logic [15:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(negedge ref_clk);
      d = rdata;
      @(posedge ref_clk);
   endtask : rd_reg
   task rd_chk(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
      logic [15:0] d;
      rd_reg(a, d);
      `CHK(d & m, e)
   endtask : rd_chk
   task put(input logic [11:0] a, input logic [15:0] k, input logic [15:0] v);
      u_mem.mem[{a, 2'h0}] = k;
      u_mem.mem[{a, 2'h1}] = v;
      u_mem.mem[{a, 2'h2}] = 16'h5A5A;
      u_mem.mem[{a, 2'h3}] = ~k;
   endtask : put
   task tbl;
      for (int a = 16; a < 21; a++) begin
         put(12'(a), (a == 17 || a == 19) ? 16'h0123 : 16'(a), (a == 19) ? 16'h2222 : 16'h1111);
      end
   endtask : tbl
   task prep(input logic [15:0] m);
      mode = m;
      wr_reg(icts_pkg::A_NOC6, 16'h0008);
      wr_reg(icts_pkg::A_IRQ_ST, 16'h0007);
      wr_reg(icts_pkg::A_NOC7, 16'h0010);
      wr_reg(icts_pkg::A_NOC6, mode | 16'h0001);
      wr_reg(icts_pkg::A_NOC7, 16'h0014);
      wr_reg(icts_pkg::A_NOC6, mode | 16'h0002);
   endtask : prep
   task ld_req(input logic id, input logic [15:0] w);
      wr_reg(icts_pkg::A_NOC5, {id, 15'h0000});
      wr_reg(icts_pkg::A_NOC7, w);
      wr_reg(icts_pkg::A_NOC6, mode | 16'h0004);
   endtask : ld_req
   task go;
      logic [15:0] d;
      n_acks = 0;
      n_wr = 0;
      wr_reg(icts_pkg::A_NOC6, mode | 16'h0010);
      for (int i = 0; i < 300; i++) begin
         rd_reg(icts_pkg::A_NIC6, d);
         if (d[0] === 1'b0) break;
      end
      `CHK(d[0], 1'b0)
   endtask : go
   // ********
   // scenarios
   // ********
   task t_reset;
      for (int a = 0; a < 8; a++) begin
         rd_chk(3'(a), 16'hFFFF, (a == 4) ? 16'h0010 : 16'h0000);
      end
      wr_reg(icts_pkg::A_NOC7, 16'hBEEF);
      rd_chk(icts_pkg::A_NOC7, 16'hFFFF, 16'hBEEF);
      @(negedge ref_clk);
      `CHK(rdata, 16'h0000)
      @(posedge ref_clk);
   endtask : t_reset
   task t_key(input logic b, input logic [11:0] e);
      prep(b ? 16'h0040 : 16'h0000);
      ld_req(1'b0, 16'h0123);
      go;
      rd_chk(icts_pkg::A_NIC7, 16'h0FFF, {4'h0, e});
      rd_chk(icts_pkg::A_NIC6, 16'h006A, 16'h0008);
      `CHK(n_acks, 8)
      rd_chk(icts_pkg::A_IRQ_ST, 16'h0007, 16'h0003);
      `CHK(irq, 1'b0)
      wr_reg(icts_pkg::A_IRQ_MASK, 16'h0007);
      `CHK(irq, 1'b1)
      wr_reg(icts_pkg::A_IRQ_ST, 16'h0002);
      `CHK(irq, 1'b1)
      wr_reg(icts_pkg::A_IRQ_ST, 16'h0001);
      `CHK(irq, 1'b0)
      wr_reg(icts_pkg::A_IRQ_MASK, 16'h0000);
   endtask : t_key
   task t_va;
      prep(16'h0000);
      ld_req(1'b1, 16'h0123);
      ld_req(1'b1, 16'h2222);
      go;
      rd_chk(icts_pkg::A_NIC7, 16'h0FFF, 16'h0013);
      rd_chk(icts_pkg::A_NIC6, 16'h0028, 16'h0020);
      n_wr = 0;
      // spoil the stored word so only the write back can restore it
      u_mem.mem[{12'h013, 2'h1}] = 16'h0000;
      wr_reg(icts_pkg::A_NOC6, 16'h0020);
      for (int i = 0; i < 60 && n_wr < 4; i++) @(posedge ref_clk);
      `CHK(n_wr, 4)
      `CHK(u_mem.mem[{12'h013, 2'h1}], 16'h2222)
   endtask : t_va
   task t_miss;
      prep(16'h0000);
      ld_req(1'b0, 16'h0777);
      go;
      rd_chk(icts_pkg::A_NIC6, 16'h0048, 16'h0040);
      rd_chk(icts_pkg::A_NIC7, 16'h0FFF, 16'h0014);
      rd_chk(icts_pkg::A_IRQ_ST, 16'h0007, 16'h0001);
      `CHK(n_acks, 20)
   endtask : t_miss
   task t_del;
      slow <= 4'h2;
      prep(16'h0000);
      ld_req(1'b0, 16'h2123);
      go;
      rd_chk(icts_pkg::A_NIC6, 16'h004A, 16'h004A);
      rd_chk(icts_pkg::A_NIC7, 16'h0FFF, 16'h0014);
      `CHK(u_mem.mem[{12'h011, 2'h0}], 16'h8123)
      `CHK(u_mem.mem[{12'h013, 2'h0}], 16'h8123)
      `CHK(u_mem.mem[{12'h012, 2'h0}], 16'h0012)
      `CHK(u_mem.mem[{12'h011, 2'h1}], 16'h1111)
      `CHK(u_mem.mem[{12'h013, 2'h3}], 16'hFEDC)
      `CHK(n_wr, 8)
      // one-request mode: the nulled entry now hits request 0
      prep(16'h0080);
      ld_req(1'b0, 16'h0777);
      go;
      rd_chk(icts_pkg::A_NIC7, 16'h0FFF, 16'h0011);
      rd_chk(icts_pkg::A_NIC6, 16'h0028, 16'h0008);
      tbl;
   endtask : t_del
   task t_perr;
      perr_en <= 1'b1;
      perr_addr <= 12'h012;
      prep(16'h0000);
      ld_req(1'b0, 16'h2123);
      go;
      rd_chk(icts_pkg::A_NIC5, 16'h000F, 16'h0001);
      rd_chk(icts_pkg::A_NIC7, 16'h0FFF, 16'h0012);
      rd_chk(icts_pkg::A_NIC6, 16'h0040, 16'h0000);
      rd_chk(icts_pkg::A_IRQ_ST, 16'h0004, 16'h0004);
      `CHK(u_mem.mem[{12'h013, 2'h0}], 16'h0123)
      perr_en <= 1'b0;
      tbl;
   endtask : t_perr
   task t_clr;
      slow <= 4'h8;
      prep(16'h0000);
      ld_req(1'b0, 16'h2123);
      wr_reg(icts_pkg::A_NOC6, 16'h0010);
      wr_reg(icts_pkg::A_NOC6, 16'h0008);
      `CHK(mem_req | mem_we, 1'b0)
      rd_chk(icts_pkg::A_NIC6, 16'h0041, 16'h0000);
   endtask : t_clr
   task complete_run;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      {addr, wdata, wr, rd, slow, perr_en, perr_addr, mode} = '0;
      {failures, n_checks, cycles, n_acks, n_wr} = '0;
      tbl;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_reset;
      t_key(1'b0, 12'h011);
      t_key(1'b1, 12'h013);
      t_va;
      t_miss;
      t_del;
      t_perr;
      t_clr;
      complete_run;
   end
endmodule : test_index_compare_table_search
